// file: msato_core.sv
// Datapath for skip, subtract, swap, table read and xor operations
// Function
// RULE_01: Byte fill writes all ones, flags kept
// RULE_02: Bit fill sets one bit only
// RULE_03: Increment memory, skip when result zero
// RULE_04: Increment into accumulator, skip on zero
// RULE_05: Skip-type operations take two machine cycles; the code records two only when the skip is taken, one otherwise
// RULE_06: Skip when selected bit is one
// RULE_07: Skip when selected bit is zero
// RULE_08: Skip when whole byte is zero
// RULE_09: Copy byte to accumulator, skip on zero
// RULE_10: Accumulator minus memory into accumulator, flags
// RULE_11: Accumulator minus memory into memory, flags
// RULE_12: Accumulator minus constant into accumulator, flags
// RULE_13: Subtract carry is inverted borrow
// RULE_14: Swap nibbles of byte in place
// RULE_15: Swapped nibbles go to accumulator
// RULE_16: Table fetch from current page
// RULE_17: Table fetch from last page
// RULE_18: Xor memory into accumulator, zero flag
// RULE_19: Xor into memory, zero flag only
// RULE_20: Xor constant into accumulator, zero flag
// RULE_21: Decrement into accumulator, skip on zero
// RULE_22: Skipped slot is a dummy with no writes
`default_nettype none
module msato_core (
  input  wire logic                            clk_i,
  input  wire logic                            resetn_i,
  input  wire logic [2:0]                      avs_address_i,
  input  wire logic                            avs_read_i,
  input  wire logic                            avs_write_i,
  input  wire logic [31:0]                     avs_writedata_i,
  output logic [31:0]                          avs_readdata_o,
  output logic                                 avs_waitrequest_o,
  output logic [msato_pkg::PROG_AW-1:0]        prog_addr_o,
  output logic                                 prog_rd_o,
  input  wire logic [15:0]                     prog_data_i,
  output logic                                 skip_o,
  output logic                                 busy_o
);
  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    msato_pkg::msato_est_t          est;        // Engine state
    msato_pkg::msato_cmd_t          cmd;        // Operation in flight
    logic [7:0]                     acc;        // Accumulator
    msato_pkg::msato_flags_t        flg;        // Status flags
    logic [7:0]                     table_pointer;    // Table pointer
    logic [7:0]                     table_high_latch; // Table high latch
    logic [msato_pkg::PAGE_W-1:0]   page;       // Current code page
    logic [msato_pkg::DMEM_AW-1:0]  dptr;       // Software memory pointer
    logic                           skip_taken; // Last op skipped
    logic [1:0]                     cycles;     // Machine cycles of last op
    logic [1:0]                     bus_cnt;    // Bus answer delay count
    logic                           waitreq;    // Bus wait output
    logic [31:0]                    rdata;      // Bus read data output
    logic [msato_pkg::PROG_AW-1:0]  prog_addr;  // Program word address
    logic                           prog_rd;    // Program read strobe
    logic                           skip;       // Dummy slot marker
    logic                           busy;       // Engine busy output
  } msato_state_t;

  msato_state_t               st_r;       // Registered state
  msato_state_t               st_nxt;     // Next state
  msato_pkg::msato_dmem_wr_t  dmem_wr;    // Memory write port
  logic [msato_pkg::DMEM_AW-1:0] dmem_raddr; // Memory read address
  logic [7:0]                 dmem_rdata; // Memory read data
  logic [7:0]                 m_val;      // Operand byte
  logic [7:0]                 m_bit;      // One-hot bit select
  logic [7:0]                 res;        // Scratch result
  msato_pkg::msato_sub_t      sub;        // Subtraction outcome
  logic                       req;        // Bus request present
  logic                       stall;      // Bus request held off
  logic                       do_skip;    // Skip decision

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Subtract with flags; carry is the inverse of the borrow
  function automatic msato_pkg::msato_sub_t sub_calc(
    input logic [7:0] a,
    input logic [7:0] b
  );
    logic [8:0] full;
    logic [4:0] low;
    msato_pkg::msato_sub_t o;
    full = {1'b0, a} - {1'b0, b};
    low  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    o.res                   = full[7:0];
    o.flg.carry_flag        = ~full[8];                   // RULE_13
    o.flg.nibble_carry_flag = ~low[4];
    o.flg.zero_flag         = (full[7:0] == 8'h00);
    o.flg.signed_wrap_flag  = (a[7] ^ b[7]) & (a[7] ^ full[7]);
    return o;
  endfunction

  // Register read-back decode; unmapped words read as zero
  function automatic logic [31:0] reg_read(
    input logic [2:0]   addr,
    input msato_state_t s,
    input logic [7:0]   mem
  );
    logic [31:0] d;
    d = msato_pkg::RD_UNMAPPED;
    case (addr)
      msato_pkg::REG_CMD: begin
        d[msato_pkg::CMD_OP_LSB +: 5]   = s.cmd.op;
        d[msato_pkg::CMD_BIT_LSB +: 3]  = s.cmd.bit_idx;
        d[msato_pkg::CMD_ADDR_LSB +: msato_pkg::DMEM_AW] = s.cmd.addr;
        d[msato_pkg::CMD_IMM_LSB +: 8]  = s.cmd.imm;
      end
      msato_pkg::REG_ACC: begin
        d[7:0] = s.acc;
      end
      msato_pkg::REG_STAT: begin
        d[3:0]                          = s.flg;
        d[msato_pkg::STAT_BUSY]         = s.busy;
        d[msato_pkg::STAT_SKIP]         = s.skip_taken;
        d[msato_pkg::STAT_CYC_LSB +: 2] = s.cycles;
      end
      msato_pkg::REG_TBL: begin
        d[7:0]                          = s.table_pointer;
        d[msato_pkg::TBL_HIGH_LSB +: 8] = s.table_high_latch;
        d[msato_pkg::TBL_PAGE_LSB +: msato_pkg::PAGE_W] = s.page;
      end
      msato_pkg::REG_DPTR: begin
        d[msato_pkg::DMEM_AW-1:0] = s.dptr;
      end
      msato_pkg::REG_DDATA: begin
        d[7:0] = mem;
      end
      default: begin
        d = msato_pkg::RD_UNMAPPED;
      end
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Data memory
  msato_dmem u_dmem (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .wr_i     (dmem_wr),
    .raddr_i  (dmem_raddr),
    .rdata_o  (dmem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, then engine
  always_comb begin
    st_nxt     = st_r;
    dmem_wr    = '0;
    m_val      = dmem_rdata;
    m_bit      = msato_pkg::BYTE_ONE << st_r.cmd.bit_idx;
    res        = 8'h00;
    sub        = '0;
    do_skip    = 1'b0;
    // Engine owns the memory port while busy
    dmem_raddr = st_r.busy ? st_r.cmd.addr : st_r.dptr;
    // Single-cycle strobes drop by default
    st_nxt.skip    = 1'b0;
    st_nxt.prog_rd = 1'b0;

    // Bus: writes and memory-window reads wait out a busy engine
    req   = avs_read_i | avs_write_i;
    stall = st_r.busy & (avs_write_i | (avs_address_i == msato_pkg::REG_DDATA));
    st_nxt.waitreq = 1'b1;
    if (req && st_r.waitreq && !stall) begin
      // Fixed delay lets a fresh memory read settle
      if (st_r.bus_cnt == msato_pkg::ACK_DELAY) begin
        st_nxt.waitreq = 1'b0;
        st_nxt.bus_cnt = 2'h0;
        st_nxt.rdata   = reg_read(avs_address_i, st_r, dmem_rdata);
      end else begin
        st_nxt.bus_cnt = st_r.bus_cnt + 2'h1;
      end
    end else if (stall) begin
      // Restart the count so read data is never stale
      st_nxt.bus_cnt = 2'h0;
    end

    // Write takes effect on the cycle wait is low
    if (avs_write_i && !st_r.waitreq) begin
      case (avs_address_i)
        msato_pkg::REG_CMD: begin
          st_nxt.cmd.op      = msato_pkg::msato_op_t'(
                               avs_writedata_i[msato_pkg::CMD_OP_LSB +: 5]);
          st_nxt.cmd.bit_idx = avs_writedata_i[msato_pkg::CMD_BIT_LSB +: 3];
          st_nxt.cmd.addr    =
            avs_writedata_i[msato_pkg::CMD_ADDR_LSB +: msato_pkg::DMEM_AW];
          st_nxt.cmd.imm     = avs_writedata_i[msato_pkg::CMD_IMM_LSB +: 8];
          st_nxt.skip_taken  = 1'b0;
          st_nxt.est         = msato_pkg::E_FETCH;
        end
        msato_pkg::REG_ACC: begin
          st_nxt.acc = avs_writedata_i[7:0];
        end
        msato_pkg::REG_STAT: begin
          st_nxt.flg = avs_writedata_i[3:0];
        end
        msato_pkg::REG_TBL: begin
          st_nxt.table_pointer = avs_writedata_i[7:0];
          st_nxt.page =
            avs_writedata_i[msato_pkg::TBL_PAGE_LSB +: msato_pkg::PAGE_W];
        end
        msato_pkg::REG_DPTR: begin
          st_nxt.dptr = avs_writedata_i[msato_pkg::DMEM_AW-1:0];
        end
        msato_pkg::REG_DDATA: begin
          dmem_wr = '{we: 1'b1, addr: st_r.dptr, data: avs_writedata_i[7:0]};
        end
        default: begin
          // Unmapped: acknowledged and dropped
        end
      endcase
    end

    // Engine
    case (st_r.est)
      msato_pkg::E_IDLE: begin
        // Waiting for a command write
      end
      msato_pkg::E_FETCH: begin
        // Operand read issued, data valid next cycle
        st_nxt.est = msato_pkg::E_EXEC;
      end
      msato_pkg::E_EXEC: begin
        case (st_r.cmd.op)
          msato_pkg::OP_SET_BYTE: begin
            dmem_wr = '{we: 1'b1, addr: st_r.cmd.addr,
                        data: msato_pkg::BYTE_ONES};            // RULE_01
          end
          msato_pkg::OP_SET_BIT: begin
            dmem_wr = '{we: 1'b1, addr: st_r.cmd.addr,
                        data: m_val | m_bit};                   // RULE_02
          end
          msato_pkg::OP_INC_SKIP: begin
            res     = m_val + msato_pkg::BYTE_ONE;
            dmem_wr = '{we: 1'b1, addr: st_r.cmd.addr, data: res}; // RULE_03
            do_skip = (res == 8'h00);                           // RULE_03
          end
          msato_pkg::OP_INC_ACC_SKIP: begin
            res        = m_val + msato_pkg::BYTE_ONE;
            st_nxt.acc = res;                                   // RULE_04
            do_skip    = (res == 8'h00);                        // RULE_04
          end
          msato_pkg::OP_DEC_ACC_SKIP: begin
            res        = m_val - msato_pkg::BYTE_ONE;
            st_nxt.acc = res;                                   // RULE_21
            do_skip    = (res == 8'h00);                        // RULE_21
          end
          msato_pkg::OP_SKIP_BIT_NZ: begin
            do_skip = |(m_val & m_bit);                         // RULE_06
          end
          msato_pkg::OP_SKIP_BIT_Z: begin
            do_skip = ~|(m_val & m_bit);                        // RULE_07
          end
          msato_pkg::OP_SKIP_BYTE_Z: begin
            do_skip = (m_val == 8'h00);                         // RULE_08
          end
          msato_pkg::OP_COPY_SKIP_Z: begin
            st_nxt.acc = m_val;                                 // RULE_09
            do_skip    = (m_val == 8'h00);                      // RULE_09
          end
          msato_pkg::OP_SUB_ACC: begin
            sub        = sub_calc(st_r.acc, m_val);
            st_nxt.acc = sub.res;                               // RULE_10
            st_nxt.flg = sub.flg;                               // RULE_10
          end
          msato_pkg::OP_SUB_MEM: begin
            sub        = sub_calc(st_r.acc, m_val);
            dmem_wr    = '{we: 1'b1, addr: st_r.cmd.addr,
                           data: sub.res};                      // RULE_11
            st_nxt.flg = sub.flg;                               // RULE_11
          end
          msato_pkg::OP_SUB_IMM: begin
            sub        = sub_calc(st_r.acc, st_r.cmd.imm);
            st_nxt.acc = sub.res;                               // RULE_12
            st_nxt.flg = sub.flg;                               // RULE_12
          end
          msato_pkg::OP_SWAP_MEM: begin
            dmem_wr = '{we: 1'b1, addr: st_r.cmd.addr,
                        data: {m_val[3:0], m_val[7:4]}};        // RULE_14
          end
          msato_pkg::OP_SWAP_ACC: begin
            st_nxt.acc = {m_val[3:0], m_val[7:4]};              // RULE_15
          end
          msato_pkg::OP_TBL_CUR: begin
            st_nxt.prog_addr = {st_r.page, st_r.table_pointer}; // RULE_16
            st_nxt.prog_rd   = 1'b1;
            st_nxt.est       = msato_pkg::E_TBLRD;
          end
          msato_pkg::OP_TBL_LAST: begin
            st_nxt.prog_addr = {msato_pkg::LAST_PAGE, st_r.table_pointer}; // RULE_17
            st_nxt.prog_rd   = 1'b1;
            st_nxt.est       = msato_pkg::E_TBLRD;
          end
          msato_pkg::OP_XOR_ACC: begin
            res                  = st_r.acc ^ m_val;
            st_nxt.acc           = res;                         // RULE_18
            st_nxt.flg.zero_flag = (res == 8'h00);              // RULE_18
          end
          msato_pkg::OP_XOR_MEM: begin
            res     = st_r.acc ^ m_val;
            dmem_wr = '{we: 1'b1, addr: st_r.cmd.addr, data: res}; // RULE_19
            st_nxt.flg.zero_flag = (res == 8'h00);              // RULE_19
          end
          msato_pkg::OP_XOR_IMM: begin
            res                  = st_r.acc ^ st_r.cmd.imm;
            st_nxt.acc           = res;                         // RULE_20
            st_nxt.flg.zero_flag = (res == 8'h00);              // RULE_20
          end
          default: begin
            // No-op and unknown codes change nothing
          end
        endcase
        // Close out the slot unless a table read continues it
        if (st_nxt.est == msato_pkg::E_EXEC) begin
          if (do_skip) begin
            st_nxt.est        = msato_pkg::E_DUMMY;             // RULE_05
            st_nxt.skip       = 1'b1;
            st_nxt.skip_taken = 1'b1;
            st_nxt.cycles     = msato_pkg::CYC_TWO;             // RULE_05
          end else begin
            st_nxt.est    = msato_pkg::E_IDLE;
            st_nxt.cycles = msato_pkg::CYC_ONE;
          end
        end
      end
      msato_pkg::E_TBLRD: begin
        // Program word comes back the cycle after the strobe
        st_nxt.est = msato_pkg::E_TBLWR;
      end
      msato_pkg::E_TBLWR: begin
        dmem_wr = '{we: 1'b1, addr: st_r.cmd.addr,
                    data: prog_data_i[7:0]};                    // RULE_16
        st_nxt.table_high_latch = prog_data_i[15:8];            // RULE_17
        st_nxt.cycles = msato_pkg::CYC_ONE;
        st_nxt.est    = msato_pkg::E_IDLE;
      end
      msato_pkg::E_DUMMY: begin
        // Fetched instruction discarded: nothing is written
        st_nxt.est = msato_pkg::E_IDLE;                         // RULE_22
      end
      default: begin
        st_nxt.est = msato_pkg::E_IDLE;
      end
    endcase

    st_nxt.busy = (st_nxt.est != msato_pkg::E_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r         <= '0;
      st_r.acc     <= msato_pkg::ACC_RST;
      st_r.waitreq <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  assign avs_readdata_o    = st_r.rdata;
  assign avs_waitrequest_o = st_r.waitreq;
  assign prog_addr_o       = st_r.prog_addr;
  assign prog_rd_o         = st_r.prog_rd;
  assign skip_o            = st_r.skip;
  assign busy_o            = st_r.busy;
endmodule
`default_nettype wire

// file: msato_pkg.sv
// Constants and carrier types shared by the datapath and its memory
`default_nettype none
package msato_pkg;
  // Geometry
  localparam int unsigned DMEM_AW    = 5;   // Data memory address width
  localparam int unsigned DMEM_DEPTH = 32;  // Data memory bytes
  localparam int unsigned PROG_AW    = 14;  // Program word address width
  localparam int unsigned PAGE_W     = 6;   // Program page number width
  localparam logic [PAGE_W-1:0] LAST_PAGE = 6'h3f;

  // Register word indices (byte address is four times the index)
  localparam logic [2:0] REG_CMD   = 3'h0;
  localparam logic [2:0] REG_ACC   = 3'h1;
  localparam logic [2:0] REG_STAT  = 3'h2;
  localparam logic [2:0] REG_TBL   = 3'h3;
  localparam logic [2:0] REG_DPTR  = 3'h4;
  localparam logic [2:0] REG_DDATA = 3'h5;

  // Field positions
  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_BIT_LSB  = 8;
  localparam int unsigned CMD_ADDR_LSB = 16;
  localparam int unsigned CMD_IMM_LSB  = 24;
  localparam int unsigned STAT_BUSY    = 8;
  localparam int unsigned STAT_SKIP    = 9;
  localparam int unsigned STAT_CYC_LSB = 12;
  localparam int unsigned TBL_HIGH_LSB = 8;
  localparam int unsigned TBL_PAGE_LSB = 16;

  // Values and timing
  localparam logic [7:0]  BYTE_ONES  = 8'hff;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [1:0]  CYC_ONE    = 2'h1;
  localparam logic [1:0]  CYC_TWO    = 2'h2;
  localparam logic [1:0]  ACK_DELAY  = 2'h2;  // Count that ends the wait; answer follows three wait cycles
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // Operation codes
  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_SET_BYTE     = 5'h01,
    OP_SET_BIT      = 5'h02,
    OP_INC_SKIP     = 5'h03,
    OP_INC_ACC_SKIP = 5'h04,
    OP_DEC_ACC_SKIP = 5'h05,
    OP_SKIP_BIT_NZ  = 5'h06,
    OP_SKIP_BIT_Z   = 5'h07,
    OP_SKIP_BYTE_Z  = 5'h08,
    OP_COPY_SKIP_Z  = 5'h09,
    OP_SUB_ACC      = 5'h0a,
    OP_SUB_MEM      = 5'h0b,
    OP_SUB_IMM      = 5'h0c,
    OP_SWAP_MEM     = 5'h0d,
    OP_SWAP_ACC     = 5'h0e,
    OP_TBL_CUR      = 5'h0f,
    OP_TBL_LAST     = 5'h10,
    OP_XOR_ACC      = 5'h11,
    OP_XOR_MEM      = 5'h12,
    OP_XOR_IMM      = 5'h13
  } msato_op_t;

  // Engine states
  typedef enum logic [2:0] {
    E_IDLE  = 3'h0,
    E_FETCH = 3'h1,
    E_EXEC  = 3'h2,
    E_TBLRD = 3'h3,
    E_TBLWR = 3'h4,
    E_DUMMY = 3'h5
  } msato_est_t;

  typedef struct packed {
    logic [7:0]         imm;
    logic [DMEM_AW-1:0] addr;
    logic [2:0]         bit_idx;
    msato_op_t          op;
  } msato_cmd_t;

  typedef struct packed {
    logic signed_wrap_flag;
    logic zero_flag;
    logic nibble_carry_flag;
    logic carry_flag;
  } msato_flags_t;

  typedef struct packed {
    msato_flags_t flg;
    logic [7:0]   res;
  } msato_sub_t;

  typedef struct packed {
    logic               we;
    logic [DMEM_AW-1:0] addr;
    logic [7:0]         data;
  } msato_dmem_wr_t;
endpackage
`default_nettype wire

// file: msato_dmem.sv
// Data memory: one write port, one registered read port
`default_nettype none
module msato_dmem (
  input  wire logic                              clk_i,
  input  wire logic                              resetn_i,
  input  wire msato_pkg::msato_dmem_wr_t         wr_i,
  input  wire logic [msato_pkg::DMEM_AW-1:0]     raddr_i,
  output logic [7:0]                             rdata_o
);
  typedef struct packed {
    logic [7:0] rdata;
  } msato_dm_state_t;

  logic [7:0]      mem_r [msato_pkg::DMEM_DEPTH];  // Storage, no reset
  msato_dm_state_t st_r;                           // Read register
  msato_dm_state_t st_nxt;

  // Read is old-data on a same-address write
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = mem_r[raddr_i];
  end

  // Array writes kept out of reset so it maps onto RAM
  always_ff @(posedge clk_i) begin
    if (wr_i.we) begin
      mem_r[wr_i.addr] <= wr_i.data;
    end
  end

  // Read data register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
endmodule
`default_nettype wire

// file: msato_prog_model.sv
// Behavioural program memory that answers the table fetch port
`default_nettype none
module msato_prog_model (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [13:0] prog_addr_i,
  input  wire logic        prog_rd_i,
  output logic      [15:0] prog_data_o
);
  ////////////////////////////////////////////////////////////////////////////
  timeunit 1ns;
  timeprecision 1ps;
  // Word content is a pure function of its address, so the bench can predict it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_data_o <= 16'h0f0f;
    end else if (prog_rd_i) begin
      // Valid in the cycle after the strobe, as the port expects
      prog_data_o <= {prog_addr_i[7:0] ^ 8'h96, 2'h1, prog_addr_i[13:8]};
    end else begin
      // Stale word is inverted so a late sample never passes by luck
      prog_data_o <= ~prog_data_o;
    end
  end
endmodule
`default_nettype wire

// file: msato_core_monitor.sv
// Port checker for bus handshake, skip slot and table fetch timing
`default_nettype none
module msato_core_monitor (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [2:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [13:0] prog_addr_o,
  input wire logic        prog_rd_o,
  input wire logic [15:0] prog_data_i,
  input wire logic        skip_o,
  input wire logic        busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Command accepted on the bus
  sequence s_cmd_ack;
    avs_write_i && !avs_waitrequest_o && avs_address_i == msato_pkg::REG_CMD;
  endsequence
  // Fetch and execute slots
  sequence s_busy_run;
    busy_o [*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_cmd_starts: assert property (s_cmd_ack |=> s_busy_run)
    else $error("engine not busy after command");
  a_skip_slot: assert property (skip_o |=> !skip_o && !busy_o)
    else $error("skip slot not one cycle");
  a_skip_busy: assert property (skip_o |-> busy_o)
    else $error("skip slot outside busy");
  a_fetch_pulse: assert property (prog_rd_o |=> !prog_rd_o && busy_o)
    else $error("fetch strobe wrong");
  a_fetch_busy: assert property (prog_rd_o |-> busy_o)
    else $error("fetch while idle");
  a_fetch_hold: assert property (prog_rd_o |=> $stable(prog_addr_o))
    else $error("fetch address moved");
  a_ack_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");
  a_ack_bound: assert property ((avs_read_i || avs_write_i) && !busy_o
    |-> ##[0:4] !avs_waitrequest_o) else $error("answer late");
endmodule
`default_nettype wire

// file: mcu_skip_arith_table_ops_test.sv
// Self-checking bench: register tasks drive every operation except OP_NOP and check results
`default_nettype none
module mcu_skip_arith_table_ops_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] ADR = 5'h1f; // Top byte, a boundary address
  logic        clk_i, resetn_i, avs_read_i, avs_write_i;
  logic        avs_waitrequest_o, prog_rd_o, skip_o, busy_o;
  logic [2:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [13:0] prog_addr_o;
  logic [15:0] prog_data_i;
  int          n_fail, comparisons;
  msato_core u_msato_core (.clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .prog_addr_o, .prog_rd_o,
    .prog_data_i, .skip_o, .busy_o);
  msato_prog_model u_msato_prog_model (.clk_i, .resetn_i, .prog_addr_i(prog_addr_o),
    .prog_rd_i(prog_rd_o), .prog_data_o(prog_data_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    if (n >= 64) begin
      n_fail++;
      end_of_test();
    end
    q = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask
  // Preload, run one command, wait for idle, then check every result
  task automatic tc(input logic [4:0] op, input logic [2:0] b, input logic [7:0] im, a0, m0,
                    ax, mx, input logic [3:0] fx, input logic sx);
    int n;
    bus(1'h1, msato_pkg::REG_ACC, {24'h00_0000, a0});
    bus(1'h1, msato_pkg::REG_DPTR, {27'h000_0000, ADR});
    bus(1'h1, msato_pkg::REG_DDATA, {24'h00_0000, m0});
    bus(1'h1, msato_pkg::REG_STAT, 32'h0000_000a);
    bus(1'h1, msato_pkg::REG_CMD, {im, 3'h0, ADR, 5'h00, b, 3'h0, op});
    n = 0;
    do begin
      bus(1'h0, msato_pkg::REG_STAT, 32'h0000_0000);
      n++;
    end while (q[8] !== 1'b0 && n < 16);
    if (q[8] !== 1'b0) begin
      n_fail++;
      end_of_test();
    end
    chk("skip", {7'h00, q[9]}, {7'h00, sx});
    chk("cycles", {6'h00, q[13:12]}, sx ? 8'h02 : 8'h01);
    chk("flags", {4'h0, q[3:0]}, {4'h0, fx});
    bus(1'h0, msato_pkg::REG_ACC, 32'h0000_0000);
    chk("acc", q[7:0], ax);
    bus(1'h0, msato_pkg::REG_DDATA, 32'h0000_0000);
    chk("mem", q[7:0], mx);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 3'h0;
    avs_writedata_i = 32'h0000_0000;
    n_fail = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    bus(1'h0, 3'h7, 32'h0000_0000);
    chk("unmapped", {7'h00, |q}, 8'h00);
    bus(1'h1, msato_pkg::REG_TBL, 32'h0005_0034); // Page 5, pointer 34
    tc(msato_pkg::OP_SET_BYTE, 3'h0, 8'h00, 8'h33, 8'h12, 8'h33, 8'hff, 4'ha, 1'h0);
    tc(msato_pkg::OP_SET_BIT, 3'h5, 8'h00, 8'h33, 8'h81, 8'h33, 8'ha1, 4'ha, 1'h0);
    tc(msato_pkg::OP_INC_SKIP, 3'h0, 8'h00, 8'h33, 8'hff, 8'h33, 8'h00, 4'ha, 1'h1);
    tc(msato_pkg::OP_INC_SKIP, 3'h0, 8'h00, 8'h33, 8'h10, 8'h33, 8'h11, 4'ha, 1'h0);
    tc(msato_pkg::OP_INC_ACC_SKIP, 3'h0, 8'h00, 8'h33, 8'hff, 8'h00, 8'hff, 4'ha, 1'h1);
    tc(msato_pkg::OP_DEC_ACC_SKIP, 3'h0, 8'h00, 8'h33, 8'h01, 8'h00, 8'h01, 4'ha, 1'h1);
    tc(msato_pkg::OP_SKIP_BIT_NZ, 3'h3, 8'h00, 8'h33, 8'h08, 8'h33, 8'h08, 4'ha, 1'h1);
    tc(msato_pkg::OP_SKIP_BIT_NZ, 3'h2, 8'h00, 8'h33, 8'h08, 8'h33, 8'h08, 4'ha, 1'h0);
    tc(msato_pkg::OP_SKIP_BIT_Z, 3'h3, 8'h00, 8'h33, 8'h08, 8'h33, 8'h08, 4'ha, 1'h0);
    tc(msato_pkg::OP_SKIP_BIT_Z, 3'h7, 8'h00, 8'h33, 8'h08, 8'h33, 8'h08, 4'ha, 1'h1);
    tc(msato_pkg::OP_SKIP_BYTE_Z, 3'h0, 8'h00, 8'h33, 8'h00, 8'h33, 8'h00, 4'ha, 1'h1);
    tc(msato_pkg::OP_COPY_SKIP_Z, 3'h0, 8'h00, 8'h33, 8'h00, 8'h00, 8'h00, 4'ha, 1'h1);
    tc(msato_pkg::OP_SUB_ACC, 3'h0, 8'h00, 8'h10, 8'h20, 8'hf0, 8'h20, 4'h2, 1'h0);
    tc(msato_pkg::OP_SUB_MEM, 3'h0, 8'h00, 8'h05, 8'h05, 8'h05, 8'h00, 4'h7, 1'h0);
    tc(msato_pkg::OP_SUB_IMM, 3'h0, 8'h01, 8'h80, 8'h44, 8'h7f, 8'h44, 4'h9, 1'h0);
    tc(msato_pkg::OP_SWAP_MEM, 3'h0, 8'h00, 8'h33, 8'h3c, 8'h33, 8'hc3, 4'ha, 1'h0);
    tc(msato_pkg::OP_SWAP_ACC, 3'h0, 8'h00, 8'h33, 8'ha5, 8'h5a, 8'ha5, 4'ha, 1'h0);
    tc(msato_pkg::OP_XOR_ACC, 3'h0, 8'h00, 8'h0f, 8'h0f, 8'h00, 8'h0f, 4'he, 1'h0);
    tc(msato_pkg::OP_XOR_MEM, 3'h0, 8'h00, 8'h0f, 8'hf0, 8'h0f, 8'hff, 4'ha, 1'h0);
    tc(msato_pkg::OP_XOR_IMM, 3'h0, 8'h55, 8'h55, 8'h12, 8'h00, 8'h12, 4'he, 1'h0);
    tc(msato_pkg::OP_TBL_CUR, 3'h0, 8'h00, 8'h33, 8'h00, 8'h33, 8'h45, 4'ha, 1'h0);
    tc(msato_pkg::OP_TBL_LAST, 3'h0, 8'h00, 8'h33, 8'h00, 8'h33, 8'h7f, 4'ha, 1'h0);
    bus(1'h0, msato_pkg::REG_TBL, 32'h0000_0000);
    chk("table_high", q[15:8], 8'ha2);
    end_of_test();
  end
endmodule
bind msato_core msato_core_monitor u_msato_core_monitor (.clk_i, .resetn_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
  .prog_addr_o, .prog_rd_o, .prog_data_i, .skip_o, .busy_o);
`default_nettype wire
